/* File: src/peripheral_irq_priority.sv */
// Interrupt priority, source flagging and context save logic with an AXI4-Lite register slave
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module peripheral_irq_priority #(
    parameter int STACK_DEPTH = 31
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire irq_prio_pkg::axi_req_s axi_req,
    output irq_prio_pkg::axi_rsp_s axi_rsp,
    input wire logic [1:0] can_mode,
    input wire logic [7:0] periph_one_req,
    input wire logic [7:0] periph_two_req,
    input wire logic [7:0] can_req,
    input wire logic [7:0] portb_pins,
    input wire logic timer_zero_tick,
    input wire logic [4:0] reset_cause_clear,
    input wire irq_prio_pkg::core_ctx_s core_ctx,
    output logic irq_high,
    output logic irq_low,
    output logic wake,
    output logic [irq_prio_pkg::PC_W-1:0] stack_top,
    output logic [$clog2(STACK_DEPTH+1)-1:0] stack_count,
    output logic [7:0] shadow_accumulator,
    output logic [7:0] shadow_status,
    output logic [7:0] shadow_bank_select
);
    localparam int SP_W = $clog2(STACK_DEPTH + 1);
    localparam logic [SP_W-1:0] SP_FULL = SP_W'(STACK_DEPTH);

    generate
        if (STACK_DEPTH < 2 || STACK_DEPTH > 31) begin : g_bad_depth
            $error("STACK_DEPTH must lie between 2 and 31");
        end
    endgenerate

    typedef struct packed {
        logic [7:0] prio_one;
        logic [7:0] prio_two;
        logic [7:0] prio_three;
        logic [7:0] reset_cause;
        logic [7:0] ctrl_main;
        logic [7:0] ctrl_second;
        logic [7:0] ctrl_third;
        logic [15:0] timer_count;
        logic timer_wide;
        logic timer_run;
        logic [7:0] pins_prev;
        logic irq_high;
        logic irq_low;
        logic wake;
        logic aw_hold;
        logic [31:0] awaddr;
        logic w_hold;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        irq_prio_pkg::axi_rsp_s rsp;
        logic [irq_prio_pkg::PC_W-1:0] top_pc;
        logic [STACK_DEPTH-1:0][irq_prio_pkg::PC_W-1:0] stk;
        logic [SP_W-1:0] sp;
        logic [7:0] sh_acc;
        logic [7:0] sh_status;
        logic [7:0] sh_bank;
    } state_s;

    state_s s_q;
    state_s s_d;

    logic do_write;
    logic wr_lane0;
    logic [7:0] wbyte;
    logic [7:0] prio_three_eff;
    logic [23:0] per_act;
    logic [23:0] per_pri;
    logic [4:0] core_act;
    logic [4:0] core_pri;
    logic [2:0] ext_pin;
    logic [2:0] ext_edge;
    logic [2:0] ext_sel;
    logic portb_change;
    logic timer_ovf;
    logic wr_timer;
    logic levels_on;

    assign levels_on = s_q.reset_cause[irq_prio_pkg::PRIORITY_LEVELS_ENABLE];
    assign do_write = s_q.aw_hold && s_q.w_hold && !s_q.rsp.bvalid;
    assign wr_lane0 = do_write && s_q.wstrb[0];
    assign wbyte = s_q.wdata[7:0];
    assign wr_timer = do_write && (s_q.awaddr == irq_prio_pkg::OFF_TIMER_ZERO);

    // Mode-dependent view of the CAN priority bits
    always_comb begin
        prio_three_eff = s_q.prio_three;
        if (can_mode != irq_prio_pkg::CAN_LEGACY) begin
            prio_three_eff[3:2] = 2'b00;
        end
        if (can_mode == irq_prio_pkg::CAN_ENHANCED) begin
            prio_three_eff[0] = 1'b0;
        end
    end

    // Source vectors: the first register's bit 7 down to the CAN register's bit 0
    assign per_act = {periph_one_req, periph_two_req & irq_prio_pkg::WMASK_PRIO_TWO,
        can_req & {7'h7f, can_mode != irq_prio_pkg::CAN_ENHANCED}};
    assign per_pri = {s_q.prio_one, s_q.prio_two, prio_three_eff};
    assign core_act = {
        s_q.ctrl_main[irq_prio_pkg::TIMER_ZERO_OVF_FLAG]
            & s_q.ctrl_main[irq_prio_pkg::TIMER_ZERO_OVF_ENABLE],
        s_q.ctrl_main[irq_prio_pkg::EXT_ZERO_FLAG] & s_q.ctrl_main[irq_prio_pkg::EXT_ZERO_ENABLE],
        s_q.ctrl_main[irq_prio_pkg::PORTB_CHANGE_FLAG]
            & s_q.ctrl_main[irq_prio_pkg::PORTB_CHANGE_ENABLE],
        s_q.ctrl_third[irq_prio_pkg::EXT_ONE_FLAG] & s_q.ctrl_third[irq_prio_pkg::EXT_ONE_ENABLE],
        s_q.ctrl_third[irq_prio_pkg::EXT_TWO_FLAG] & s_q.ctrl_third[irq_prio_pkg::EXT_TWO_ENABLE]
    };
    assign core_pri = {
        s_q.ctrl_second[irq_prio_pkg::TIMER_ZERO_OVF_PRIORITY],
        1'b1,
        s_q.ctrl_second[irq_prio_pkg::PORTB_CHANGE_PRIORITY],
        s_q.ctrl_third[irq_prio_pkg::EXT_ONE_PRIORITY],
        s_q.ctrl_third[irq_prio_pkg::EXT_TWO_PRIORITY]
    };

    // Edge detection per external pin
    assign ext_pin = portb_pins[2:0];
    assign ext_sel = {s_q.ctrl_second[irq_prio_pkg::EXT_EDGE_SELECT_ZERO - 2],
        s_q.ctrl_second[irq_prio_pkg::EXT_EDGE_SELECT_ZERO - 1],
        s_q.ctrl_second[irq_prio_pkg::EXT_EDGE_SELECT_ZERO]};
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_ext
            assign ext_edge[gi] = ext_sel[gi] ? (ext_pin[gi] && !s_q.pins_prev[gi])
                                              : (!ext_pin[gi] && s_q.pins_prev[gi]);
        end
    endgenerate

    assign portb_change = |(portb_pins[7:4] ^ s_q.pins_prev[7:4]);
    assign timer_ovf = s_q.timer_run && timer_zero_tick && !wr_timer
        && (s_q.timer_wide ? (s_q.timer_count == 16'hffff)
                           : (s_q.timer_count[7:0] == 8'hff));

    always_comb begin
        s_d = s_q;
        // Register writes from the bus
        if (wr_lane0) begin
            case (s_q.awaddr)
                irq_prio_pkg::OFF_PRIO_ONE: s_d.prio_one = wbyte;
                irq_prio_pkg::OFF_PRIO_TWO: s_d.prio_two = wbyte & irq_prio_pkg::WMASK_PRIO_TWO;
                irq_prio_pkg::OFF_PRIO_THREE: s_d.prio_three = wbyte;
                irq_prio_pkg::OFF_RESET_CAUSE: begin
                    s_d.reset_cause = (s_q.reset_cause & ~irq_prio_pkg::WMASK_RESET_CAUSE)
                        | (wbyte & irq_prio_pkg::WMASK_RESET_CAUSE);
                end
                irq_prio_pkg::OFF_CTRL_MAIN: s_d.ctrl_main = wbyte;
                irq_prio_pkg::OFF_CTRL_SECOND: begin
                    s_d.ctrl_second = wbyte & irq_prio_pkg::WMASK_CTRL_SECOND;
                end
                irq_prio_pkg::OFF_CTRL_THIRD: begin
                    s_d.ctrl_third = wbyte & irq_prio_pkg::WMASK_CTRL_THIRD;
                end
                irq_prio_pkg::OFF_TIMER_ZERO: s_d.timer_count[7:0] = wbyte;
                default: ;
            endcase
        end
        if (wr_timer && s_q.wstrb[1]) begin
            s_d.timer_count[15:8] = s_q.wdata[15:8];
        end
        if (wr_timer && s_q.wstrb[2]) begin
            s_d.timer_wide = s_q.wdata[irq_prio_pkg::TIMER_WIDE_MODE];
            s_d.timer_run = s_q.wdata[irq_prio_pkg::TIMER_RUN];
        end
        if (can_mode != irq_prio_pkg::CAN_LEGACY) begin
            s_d.prio_three[3:2] = 2'b00;
        end
        // Hardware clears the active-low reset-cause flags
        s_d.reset_cause[4:0] = s_d.reset_cause[4:0] & ~reset_cause_clear;

        // Timer0; in 8-bit mode the high byte stays put
        if (s_q.timer_run && timer_zero_tick && !wr_timer) begin
            if (s_q.timer_wide) begin
                s_d.timer_count = s_q.timer_count + 16'h0001;
            end else begin
                s_d.timer_count[7:0] = s_q.timer_count[7:0] + 8'h01;
            end
        end

        // Hardware sets beat a software clear in the same cycle
        if (timer_ovf) s_d.ctrl_main[irq_prio_pkg::TIMER_ZERO_OVF_FLAG] = 1'b1;
        if (ext_edge[0]) s_d.ctrl_main[irq_prio_pkg::EXT_ZERO_FLAG] = 1'b1;
        if (ext_edge[1]) s_d.ctrl_third[irq_prio_pkg::EXT_ONE_FLAG] = 1'b1;
        if (ext_edge[2]) s_d.ctrl_third[irq_prio_pkg::EXT_TWO_FLAG] = 1'b1;
        if (portb_change) s_d.ctrl_main[irq_prio_pkg::PORTB_CHANGE_FLAG] = 1'b1;
        s_d.pins_prev = portb_pins;

        // Request generation
        if (levels_on) begin
            s_d.irq_high = s_q.ctrl_main[irq_prio_pkg::GLOBAL_IRQ_ENABLE]
                && (|(per_act & per_pri) || |(core_act & core_pri));
            s_d.irq_low = s_q.ctrl_main[irq_prio_pkg::GLOBAL_IRQ_ENABLE]
                && s_q.ctrl_main[irq_prio_pkg::PERIPHERAL_IRQ_GATE]
                && (|(per_act & ~per_pri) || |(core_act & ~core_pri));
        end else begin
            s_d.irq_high = s_q.ctrl_main[irq_prio_pkg::GLOBAL_IRQ_ENABLE] && (|core_act
                || (s_q.ctrl_main[irq_prio_pkg::PERIPHERAL_IRQ_GATE] && |per_act));
            s_d.irq_low = 1'b0;
        end
        // Wake ignores the global enable; the core decides on vectoring
        s_d.wake = core_act[3] || core_act[1] || core_act[0];

        // Context save on entry, restore on fast return
        if (core_ctx.entry) begin
            s_d.stk = {s_q.stk[STACK_DEPTH-2:0], s_q.top_pc};
            s_d.top_pc = core_ctx.pc;
            s_d.sh_acc = core_ctx.working_accumulator;
            s_d.sh_status = core_ctx.status;
            s_d.sh_bank = core_ctx.bank_select_reg;
            if (s_q.sp != SP_FULL) s_d.sp = s_q.sp + SP_W'(1);
        end else if (core_ctx.fast_return && s_q.sp != '0) begin
            s_d.top_pc = s_q.stk[0];
            s_d.stk = {{irq_prio_pkg::PC_W{1'b0}}, s_q.stk[STACK_DEPTH-1:1]};
            s_d.sp = s_q.sp - SP_W'(1);
        end

        // Write channels are taken independently, answered once both are held
        if (axi_req.awvalid && s_q.rsp.awready) begin
            s_d.aw_hold = 1'b1;
            s_d.awaddr = axi_req.awaddr;
        end
        if (axi_req.wvalid && s_q.rsp.wready) begin
            s_d.w_hold = 1'b1;
            s_d.wdata = axi_req.wdata;
            s_d.wstrb = axi_req.wstrb;
        end
        if (do_write) begin
            s_d.aw_hold = 1'b0;
            s_d.w_hold = 1'b0;
            s_d.rsp.bvalid = 1'b1;
            s_d.rsp.bresp = (s_q.awaddr[31:5] == 27'h0 && s_q.awaddr[1:0] == 2'b00)
                ? irq_prio_pkg::AXI_OKAY : irq_prio_pkg::AXI_DECERR;
        end else if (s_q.rsp.bvalid && axi_req.bready) begin
            s_d.rsp.bvalid = 1'b0;
        end
        s_d.rsp.awready = !s_d.aw_hold && !s_d.rsp.bvalid;
        s_d.rsp.wready = !s_d.w_hold && !s_d.rsp.bvalid;

        // Read channel
        if (axi_req.arvalid && s_q.rsp.arready) begin
            s_d.rsp.rvalid = 1'b1;
            s_d.rsp.rresp = irq_prio_pkg::AXI_OKAY;
            s_d.rsp.rdata = 32'h0000_0000;
            case (axi_req.araddr)
                irq_prio_pkg::OFF_PRIO_ONE: s_d.rsp.rdata[7:0] = s_q.prio_one;
                irq_prio_pkg::OFF_PRIO_TWO: s_d.rsp.rdata[7:0] = s_q.prio_two;
                irq_prio_pkg::OFF_PRIO_THREE: s_d.rsp.rdata[7:0] = prio_three_eff;
                irq_prio_pkg::OFF_RESET_CAUSE: begin
                    s_d.rsp.rdata[7:0] = s_q.reset_cause & irq_prio_pkg::RMASK_RESET_CAUSE;
                end
                irq_prio_pkg::OFF_CTRL_MAIN: s_d.rsp.rdata[7:0] = s_q.ctrl_main;
                irq_prio_pkg::OFF_CTRL_SECOND: s_d.rsp.rdata[7:0] = s_q.ctrl_second;
                irq_prio_pkg::OFF_CTRL_THIRD: s_d.rsp.rdata[7:0] = s_q.ctrl_third;
                irq_prio_pkg::OFF_TIMER_ZERO: begin
                    s_d.rsp.rdata[15:0] = s_q.timer_count;
                    s_d.rsp.rdata[irq_prio_pkg::TIMER_WIDE_MODE] = s_q.timer_wide;
                    s_d.rsp.rdata[irq_prio_pkg::TIMER_RUN] = s_q.timer_run;
                end
                default: s_d.rsp.rresp = irq_prio_pkg::AXI_DECERR;
            endcase
        end else if (s_q.rsp.rvalid && axi_req.rready) begin
            s_d.rsp.rvalid = 1'b0;
        end
        s_d.rsp.arready = !s_d.rsp.rvalid;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.prio_one <= irq_prio_pkg::RST_PRIO_ONE;
            s_q.prio_two <= irq_prio_pkg::RST_PRIO_TWO;
            s_q.prio_three <= irq_prio_pkg::RST_PRIO_THREE;
            s_q.reset_cause <= irq_prio_pkg::RST_RESET_CAUSE;
            s_q.ctrl_main <= irq_prio_pkg::RST_CTRL_MAIN;
            s_q.ctrl_second <= irq_prio_pkg::RST_CTRL_SECOND;
            s_q.ctrl_third <= irq_prio_pkg::RST_CTRL_THIRD;
            s_q.rsp.awready <= 1'b1;
            s_q.rsp.wready <= 1'b1;
            s_q.rsp.arready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign axi_rsp = s_q.rsp;
    assign irq_high = s_q.irq_high;
    assign irq_low = s_q.irq_low;
    assign wake = s_q.wake;
    assign stack_top = s_q.top_pc;
    assign stack_count = s_q.sp;
    assign shadow_accumulator = s_q.sh_acc;
    assign shadow_status = s_q.sh_status;
    assign shadow_bank_select = s_q.sh_bank;

    sequence s_write_held;
        s_q.aw_hold && s_q.w_hold && !s_q.rsp.bvalid;
    endsequence
    sequence s_resp_wait;
        s_q.rsp.bvalid && !s_q.rsp.awready && !s_q.rsp.wready;
    endsequence

    a_single_level_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !levels_on |=> !irq_low) else $error("low request without priority levels");
    a_ext_zero_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
        levels_on && s_q.ctrl_main[7] && core_act[3] |=> irq_high)
        else $error("external zero did not request high");
    a_ext_edge_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
        portb_pins[0] && !s_q.pins_prev[0] && s_q.ctrl_second[6] |=> s_q.ctrl_main[1])
        else $error("rising edge missed on external zero");
    a_timer_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n)
        timer_ovf && !s_q.timer_wide |=> s_q.ctrl_main[2] && s_q.timer_count[7:0] == 8'h00)
        else $error("timer wrap did not flag");
    a_portb_change: assert property (@(posedge clk_sys) disable iff (!rst_n)
        portb_change |=> s_q.ctrl_main[0]) else $error("port change not flagged");
    a_can_forced: assert property (@(posedge clk_sys) disable iff (!rst_n)
        can_mode != 2'b00 |=> s_q.prio_three[3:2] == 2'b00) else $error("bits not forced");
    a_context_push: assert property (@(posedge clk_sys) disable iff (!rst_n)
        core_ctx.entry |=> stack_top == $past(core_ctx.pc)
            && shadow_status == $past(core_ctx.status) && s_q.stk[0] == $past(s_q.top_pc))
        else $error("context not saved on entry");
    a_gate_blocks: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !levels_on && !s_q.ctrl_main[6] && core_act == 5'h00 |=> !irq_high)
        else $error("peripheral passed closed gate");
    a_low_request: assert property (@(posedge clk_sys) disable iff (!rst_n)
        levels_on && s_q.ctrl_main[7] && s_q.ctrl_main[6] && |(per_act & ~per_pri) |=> irq_low)
        else $error("low-priority source not requested");
    a_write_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_write_held |=> s_resp_wait) else $error("write not answered");
    a_read_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
        axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid) else $error("read not answered");
    // Unmapped writes must be refused, never silently accepted
    a_bad_write_resp: assert property (@(posedge clk_sys) disable iff (!rst_n)
        do_write && s_q.awaddr > irq_prio_pkg::OFF_TIMER_ZERO
            |=> axi_rsp.bresp == irq_prio_pkg::AXI_DECERR)
        else $error("unmapped write accepted");
    a_wake_ext_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_q.ctrl_main[irq_prio_pkg::EXT_ZERO_FLAG]
            && s_q.ctrl_main[irq_prio_pkg::EXT_ZERO_ENABLE] |=> wake)
        else $error("enabled pin flag did not wake");
    a_mode_one_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        can_mode == 2'b01 && axi_req.arvalid && axi_rsp.arready
            && axi_req.araddr == irq_prio_pkg::OFF_PRIO_THREE |=> !axi_rsp.rdata[0])
        else $error("unimplemented bit read as one");
    a_fast_pop: assert property (@(posedge clk_sys) disable iff (!rst_n)
        core_ctx.fast_return && !core_ctx.entry && s_q.sp != '0
            |=> stack_top == $past(s_q.stk[0]) && stack_count == $past(s_q.sp) - SP_W'(1))
        else $error("fast return did not pop");
endmodule : peripheral_irq_priority

/* File: src/irq_prio_pkg.sv */
// Constants, register map and carrier types for the interrupt priority block
package irq_prio_pkg;
    // Register byte addresses
    localparam logic [31:0] OFF_PRIO_ONE = 32'h0000_0000;
    localparam logic [31:0] OFF_PRIO_TWO = 32'h0000_0004;
    localparam logic [31:0] OFF_PRIO_THREE = 32'h0000_0008;
    localparam logic [31:0] OFF_RESET_CAUSE = 32'h0000_000c;
    localparam logic [31:0] OFF_CTRL_MAIN = 32'h0000_0010;
    localparam logic [31:0] OFF_CTRL_SECOND = 32'h0000_0014;
    localparam logic [31:0] OFF_CTRL_THIRD = 32'h0000_0018;
    localparam logic [31:0] OFF_TIMER_ZERO = 32'h0000_001c;
    // Reset values
    localparam logic [7:0] RST_PRIO_ONE = 8'hff;
    localparam logic [7:0] RST_PRIO_TWO = 8'hdf;
    localparam logic [7:0] RST_PRIO_THREE = 8'hff;
    localparam logic [7:0] RST_RESET_CAUSE = 8'h1c;
    localparam logic [7:0] RST_CTRL_MAIN = 8'h00;
    localparam logic [7:0] RST_CTRL_SECOND = 8'hf5;
    localparam logic [7:0] RST_CTRL_THIRD = 8'hc0;
    // Writable bits per register, then the readable bits of the reset-cause register
    localparam logic [7:0] WMASK_PRIO_TWO = 8'hdf;
    localparam logic [7:0] WMASK_RESET_CAUSE = 8'hd3;
    localparam logic [7:0] WMASK_CTRL_SECOND = 8'hf5;
    localparam logic [7:0] WMASK_CTRL_THIRD = 8'hdb;
    localparam logic [7:0] RMASK_RESET_CAUSE = 8'hdf;
    // Field positions, the PC width and the AXI response codes
    localparam int PRIORITY_LEVELS_ENABLE = 7;
    localparam int GLOBAL_IRQ_ENABLE = 7;
    localparam int PERIPHERAL_IRQ_GATE = 6;
    localparam int TIMER_ZERO_OVF_ENABLE = 5;
    localparam int EXT_ZERO_ENABLE = 4;
    localparam int PORTB_CHANGE_ENABLE = 3;
    localparam int TIMER_ZERO_OVF_FLAG = 2;
    localparam int EXT_ZERO_FLAG = 1;
    localparam int PORTB_CHANGE_FLAG = 0;
    localparam int EXT_EDGE_SELECT_ZERO = 6;
    localparam int TIMER_ZERO_OVF_PRIORITY = 2;
    localparam int PORTB_CHANGE_PRIORITY = 0;
    localparam int EXT_TWO_PRIORITY = 7;
    localparam int EXT_ONE_PRIORITY = 6;
    localparam int EXT_TWO_ENABLE = 4;
    localparam int EXT_ONE_ENABLE = 3;
    localparam int EXT_TWO_FLAG = 1;
    localparam int EXT_ONE_FLAG = 0;
    localparam int TIMER_WIDE_MODE = 16;
    localparam int TIMER_RUN = 17;
    localparam int PC_W = 21;
    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_DECERR = 2'b11;

    typedef enum logic [1:0] {CAN_LEGACY, CAN_ENHANCED, CAN_FIFO} can_mode_e;

    typedef struct packed {
        logic [31:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [31:0] araddr;
        logic arvalid;
        logic rready;
    } axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_rsp_s;

    typedef struct packed {
        logic entry;
        logic fast_return;
        logic [PC_W-1:0] pc;
        logic [7:0] working_accumulator;
        logic [7:0] status;
        logic [7:0] bank_select_reg;
    } core_ctx_s;
endpackage : irq_prio_pkg

/* File: tb/core_model.sv */
// Processor core stand-in that takes interrupts and hands over its context
`timescale 1ns/1ps
module core_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic irq_high,
    input wire logic irq_low,
    input wire logic take,
    input wire logic ret,
    output irq_prio_pkg::core_ctx_s core_ctx
);
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            core_ctx <= '0;
            core_ctx.pc <= 21'h000100;
            core_ctx.working_accumulator <= 8'h5a;
            core_ctx.status <= 8'h3c;
            core_ctx.bank_select_reg <= 8'h0f;
        end else begin
            // Enters only while a request is shown, as a real core would
            core_ctx.entry <= take && (irq_high || irq_low);
            core_ctx.fast_return <= ret;
            // PC, accumulator and status move on after entry, so a late copy of them is caught; the bank select stays put
            if (core_ctx.entry) begin
                core_ctx.pc <= core_ctx.pc + 21'h000004;
                core_ctx.working_accumulator <= ~core_ctx.working_accumulator;
                core_ctx.status <= ~core_ctx.status;
            end
        end
    end
endmodule : core_model

/* File: tb/peripheral_irq_priority_tb.sv */
// Self-checking bench for the interrupt priority block
`timescale 1ns/1ps
module peripheral_irq_priority_tb;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    irq_prio_pkg::axi_req_s axi_req = '0;
    irq_prio_pkg::axi_rsp_s axi_rsp;
    irq_prio_pkg::core_ctx_s core_ctx;
    logic [1:0] can_mode = 2'h0;
    logic [7:0] periph_one_req = 8'h00;
    logic [7:0] periph_two_req = 8'h00;
    logic [7:0] can_req = 8'h00;
    logic [7:0] portb_pins = 8'h00;
    logic timer_zero_tick = 1'b0;
    logic [4:0] reset_cause_clear = 5'h00;
    logic take = 1'b0;
    logic ret = 1'b0;
    logic irq_high, irq_low, wake;
    logic [20:0] stack_top;
    logic [4:0] stack_count;
    logic [7:0] sh_acc, sh_st, sh_bank;
    logic [31:0] rdat;
    logic [1:0] rsp;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [7:0] can_exp [3] = '{8'hff, 8'hf2, 8'hf3};

    always #4 clk_sys = ~clk_sys;

    peripheral_irq_priority i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .axi_req(axi_req),
        .axi_rsp(axi_rsp), .can_mode(can_mode), .periph_one_req(periph_one_req),
        .periph_two_req(periph_two_req), .can_req(can_req), .portb_pins(portb_pins),
        .timer_zero_tick(timer_zero_tick), .reset_cause_clear(reset_cause_clear),
        .core_ctx(core_ctx), .irq_high(irq_high), .irq_low(irq_low), .wake(wake),
        .stack_top(stack_top), .stack_count(stack_count), .shadow_accumulator(sh_acc),
        .shadow_status(sh_st), .shadow_bank_select(sh_bank));
    core_model i_core (.clk_sys(clk_sys), .rst_n(rst_n), .irq_high(irq_high),
        .irq_low(irq_low), .take(take), .ret(ret), .core_ctx(core_ctx));

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic w(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : w

    // Address and data are offered together and each dropped once taken
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        axi_req.awaddr <= a;
        axi_req.wdata <= d;
        axi_req.wstrb <= 4'hf;
        axi_req.awvalid <= 1'b1;
        axi_req.wvalid <= 1'b1;
        axi_req.bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
            if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
        end while (axi_rsp.bvalid !== 1'b1);
        rsp = axi_rsp.bresp;
        axi_req.bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [31:0] a);
        @(posedge clk_sys);
        axi_req.araddr <= a;
        axi_req.arvalid <= 1'b1;
        axi_req.rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
        end while (axi_rsp.rvalid !== 1'b1);
        rdat = axi_rsp.rdata;
        rsp = axi_rsp.rresp;
        axi_req.rready <= 1'b0;
    endtask : rd

    task automatic rc(input logic [31:0] a, input logic [31:0] exp);
        rd(a);
        chk(rdat, exp);
    endtask : rc

    task automatic tick();
        @(posedge clk_sys);
        timer_zero_tick <= 1'b1;
        @(posedge clk_sys);
        timer_zero_tick <= 1'b0;
        w(3);
    endtask : tick

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            conclude();
        end
    end

    initial begin
        w(3);
        rst_n <= 1'b1;
        rc(irq_prio_pkg::OFF_PRIO_ONE, 32'hff);
        rc(irq_prio_pkg::OFF_PRIO_TWO, 32'hdf);
        rc(irq_prio_pkg::OFF_RESET_CAUSE, 32'h1c);
        wr(irq_prio_pkg::OFF_PRIO_TWO, 32'hff);
        rc(irq_prio_pkg::OFF_PRIO_TWO, 32'hdf);
        rd(32'h20);
        chk({30'h0, rsp}, {30'h0, irq_prio_pkg::AXI_DECERR});
        for (int m = 0; m < 3; m++) begin
            can_mode <= m[1:0];
            rc(irq_prio_pkg::OFF_PRIO_THREE, {24'h0, can_exp[m]});
        end
        can_mode <= 2'h0;
        @(posedge clk_sys);
        reset_cause_clear <= 5'h04;
        @(posedge clk_sys);
        reset_cause_clear <= 5'h00;
        rc(irq_prio_pkg::OFF_RESET_CAUSE, 32'h18);
        // Parallel-port priority cleared by software
        wr(irq_prio_pkg::OFF_PRIO_ONE, 32'hfe);
        periph_one_req <= 8'h01;
        wr(irq_prio_pkg::OFF_CTRL_MAIN, 32'h80);
        w(3);
        chk({31'h0, irq_high}, 32'h0);
        wr(irq_prio_pkg::OFF_CTRL_MAIN, 32'hc0);
        w(3);
        chk({30'h0, irq_high, irq_low}, 32'h2);
        wr(irq_prio_pkg::OFF_RESET_CAUSE, 32'h98);
        w(3);
        chk({30'h0, irq_high, irq_low}, 32'h1);
        periph_one_req <= 8'h00;
        wr(irq_prio_pkg::OFF_CTRL_MAIN, 32'hd0);
        portb_pins <= 8'h01;
        rc(irq_prio_pkg::OFF_CTRL_MAIN, 32'hd2);
        chk({30'h0, wake, irq_high}, 32'h3);
        wr(irq_prio_pkg::OFF_CTRL_MAIN, 32'hd0);
        portb_pins <= 8'h00;
        rc(irq_prio_pkg::OFF_CTRL_MAIN, 32'hd0);
        portb_pins <= 8'h10;
        rc(irq_prio_pkg::OFF_CTRL_MAIN, 32'hd1);
        wr(irq_prio_pkg::OFF_CTRL_MAIN, 32'h00);
        wr(irq_prio_pkg::OFF_TIMER_ZERO, 32'h0002_00ff);
        tick();
        rc(irq_prio_pkg::OFF_CTRL_MAIN, 32'h04);
        wr(irq_prio_pkg::OFF_CTRL_MAIN, 32'he4);
        w(3);
        chk({30'h0, irq_high, irq_low}, 32'h2);
        wr(irq_prio_pkg::OFF_CTRL_SECOND, 32'hf1);
        w(3);
        chk({30'h0, irq_high, irq_low}, 32'h1);
        @(posedge clk_sys);
        take <= 1'b1;
        @(posedge clk_sys);
        take <= 1'b0;
        w(3);
        chk({11'h0, stack_top}, 32'h100);
        chk({27'h0, stack_count}, 32'h1);
        chk({8'h0, sh_acc, sh_st, sh_bank}, 32'h5a3c0f);
        @(posedge clk_sys);
        ret <= 1'b1;
        @(posedge clk_sys);
        ret <= 1'b0;
        w(2);
        chk({6'h0, stack_count, stack_top}, 32'h0);
        wr(irq_prio_pkg::OFF_CTRL_MAIN, 32'h00);
        wr(irq_prio_pkg::OFF_TIMER_ZERO, 32'h0003_00ff);
        tick();
        rc(irq_prio_pkg::OFF_CTRL_MAIN, 32'h00);
        rc(irq_prio_pkg::OFF_TIMER_ZERO, 32'h0003_0100);
        wr(32'h20, 32'hff);
        chk({30'h0, rsp}, {30'h0, irq_prio_pkg::AXI_DECERR});
        wr(irq_prio_pkg::OFF_CTRL_MAIN, 32'hc0);
        chk({30'h0, rsp}, {30'h0, irq_prio_pkg::AXI_OKAY});
        // Unimplemented source bits must never raise a request
        periph_two_req <= 8'h20;
        w(3);
        chk({30'h0, irq_high, irq_low}, 32'h0);
        periph_two_req <= 8'h00;
        can_mode <= 2'h1;
        can_req <= 8'h01;
        w(3);
        chk({30'h0, irq_high, irq_low}, 32'h0);
        can_mode <= 2'h2;
        w(3);
        chk({30'h0, irq_high, irq_low}, 32'h2);
        can_req <= 8'h04;
        w(3);
        chk({30'h0, irq_high, irq_low}, 32'h1);
        can_req <= 8'h12;
        w(3);
        chk({30'h0, irq_high, irq_low}, 32'h2);
        wr(irq_prio_pkg::OFF_PRIO_THREE, 32'h1f);
        can_req <= 8'he0;
        w(3);
        chk({30'h0, irq_high, irq_low}, 32'h1);
        conclude();
    end
endmodule : peripheral_irq_priority_tb
